// ==== hdl/srsre_pkg.sv ====
// Constants, register map and state type of the instruction execution block.
// Assumes a single 100 MHz clock domain and an APB master with 32-bit data.
package srsre_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_ACC = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PC = 8'h0c;
   localparam logic [7:0] OFS_STACK = 8'h10;
   localparam logic [7:0] OFS_FADDR = 8'h14;
   localparam logic [7:0] OFS_FDATA = 8'h18;
   localparam logic [7:0] OFS_WDOG = 8'h1c;
   localparam logic [7:0] OFS_WAKE = 8'h20;

   // ****************************************
   // Field layout
   // ****************************************
   localparam int unsigned INSTR_W = 11;
   localparam int unsigned OP_LSB = 8;
   localparam int unsigned OP_MSB = 10;
   localparam int unsigned DEST_BIT = 7;
   localparam int unsigned PC_W = 13;
   localparam int unsigned SP_W = 3;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned FILE_DEPTH = 128;
   localparam int unsigned STACK_DEPTH = 8;
   localparam int unsigned ST_C = 0;
   localparam int unsigned ST_DIGIT = 1;
   localparam int unsigned ST_Z = 2;
   localparam int unsigned ST_PWRDN_N = 3;
   localparam int unsigned ST_TMOUT_N = 4;
   localparam int unsigned ST_SLEEP = 5;
   localparam int unsigned WAKE_BIT = 0;
   localparam int unsigned WD_PRESC_LSB = 8;

   // ****************************************
   // Operation codes held in the instruction register
   // ****************************************
   localparam logic [2:0] OP_NOP = 3'h0;
   localparam logic [2:0] OP_SLEEP = 3'h1;
   localparam logic [2:0] OP_RETURN = 3'h2;
   localparam logic [2:0] OP_SUBL = 3'h3;
   localparam logic [2:0] OP_RRC = 3'h4;
   localparam logic [2:0] OP_SUBF = 3'h5;

   // ****************************************
   // Reset and clear values
   // ****************************************
   localparam logic [7:0] WDOG_CLEAR = 8'h00;
   localparam logic [7:0] PRESC_CLEAR = 8'h00;
   localparam logic [7:0] PRESC_LAST = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [SP_W-1:0] SP_RESET = 3'h0;
   localparam logic [INSTR_W-1:0] INSTR_RESET = 11'h000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_FLUSH,
      ST_SLEEPING
   } srsre_state_t;

endpackage : srsre_pkg

// ==== hdl/srsre_alu.sv ====
// Arithmetic unit for the two subtractions and the rotate through carry.
// Purely combinational; the caller registers the outputs it uses, for the rotate only result and carry.
`timescale 1ns/1ps
module srsre_alu
   import srsre_pkg::*;
(
   input wire logic [2:0] op,
   input wire logic [7:0] file_val,
   input wire logic [7:0] acc_val,
   input wire logic [7:0] literal,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic dcarry_out,
   output logic zero_out
);

   // Returns {carry, digit carry, difference} of a minus b.
   // Adding the complement plus one gives carry high exactly when no borrow occurs.
   function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, ~b} + 9'h001;
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      return {full[8], low[4], full[7:0]};
   endfunction : sub8

   logic [9:0] diff;

   always_comb
   begin
      diff = 10'h000;
      result = BYTE_ZERO;
      carry_out = carry_in;
      dcarry_out = 1'b0;
      unique case (op)
         OP_SUBL:
         begin
            diff = sub8(literal, acc_val);
            {carry_out, dcarry_out, result} = diff;
         end
         OP_SUBF:
         begin
            diff = sub8(file_val, acc_val);
            {carry_out, dcarry_out, result} = diff;
         end
         OP_RRC:
         begin
            result = {carry_in, file_val[7:1]};
            carry_out = file_val[0];
         end
         default:
         begin
            result = BYTE_ZERO;
         end
      endcase
      zero_out = (result == BYTE_ZERO);
   end

endmodule : srsre_alu

// ==== hdl/srsre_top.sv ====
// Execution block for power-down, subroutine return, both subtractions and rotate right.
// Assumes an APB master on clk; software loads operands and issues instructions by register.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module srsre_top
   import srsre_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic osc_run,
   output logic sleeping
);

   // ****************************************
   // Bus slave state
   // ****************************************
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;

   // ****************************************
   // Core state
   // ****************************************
   srsre_state_t state_q, state_d;
   logic [INSTR_W-1:0] instr_q, instr_d;
   logic [7:0] acc_q, acc_d;
   logic carry_q, carry_d;
   logic dcarry_q, dcarry_d;
   logic zero_q, zero_d;
   logic timeout_flag_n_q, timeout_flag_n_d;
   logic powerdown_flag_n_q, powerdown_flag_n_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [SP_W-1:0] sp_q, sp_d;
   logic [PC_W-1:0] stack_q [STACK_DEPTH];
   logic [PC_W-1:0] stack_d [STACK_DEPTH];
   logic [FADDR_W-1:0] faddr_q, faddr_d;
   logic [7:0] file_q [FILE_DEPTH];
   logic [7:0] file_d [FILE_DEPTH];
   logic [7:0] watchdog_counter_q, watchdog_counter_d;
   logic [7:0] presc_q, presc_d;
   logic osc_run_q, osc_run_d;
   logic sleeping_q, sleeping_d;

   logic [2:0] op;
   logic dest_file;
   logic [FADDR_W-1:0] op_faddr;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_z;
   logic wr_fire;
   logic rd_take;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == OFS_INSTR || a == OFS_ACC || a == OFS_STATUS || a == OFS_PC
         || a == OFS_STACK || a == OFS_FADDR || a == OFS_FDATA || a == OFS_WDOG
         || a == OFS_WAKE;
   endfunction : is_mapped

   assign op = instr_q[OP_MSB:OP_LSB];
   assign dest_file = instr_q[DEST_BIT];
   assign op_faddr = instr_q[FADDR_W-1:0];
   assign wr_fire = psel && penable && pready_q && pwrite;
   assign rd_take = psel && penable && !pready_q;

   srsre_alu u_alu (
      .op(op),
      .file_val(file_q[op_faddr]),
      .acc_val(acc_q),
      .literal(instr_q[7:0]),
      .carry_in(carry_q),
      .result(alu_res),
      .carry_out(alu_c),
      .dcarry_out(alu_dc),
      .zero_out(alu_z)
   );

   // ****************************************
   // APB slave: one wait state, answers from registers
   // ****************************************
   always_comb
   begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      if (rd_take)
      begin
         pready_d = 1'b1;
         pslverr_d = !is_mapped(paddr);
         prdata_d = WORD_ZERO;
         if (!pwrite)
         begin
            unique case (paddr)
               OFS_INSTR: prdata_d[INSTR_W-1:0] = instr_q;
               OFS_ACC: prdata_d[7:0] = acc_q;
               OFS_STATUS:
               begin
                  prdata_d[ST_C] = carry_q;
                  prdata_d[ST_DIGIT] = dcarry_q;
                  prdata_d[ST_Z] = zero_q;
                  prdata_d[ST_PWRDN_N] = powerdown_flag_n_q;
                  prdata_d[ST_TMOUT_N] = timeout_flag_n_q;
                  prdata_d[ST_SLEEP] = sleeping_q;
               end
               OFS_PC: prdata_d[PC_W-1:0] = pc_q;
               OFS_STACK: prdata_d[SP_W-1:0] = sp_q;
               OFS_FADDR: prdata_d[FADDR_W-1:0] = faddr_q;
               OFS_FDATA: prdata_d[7:0] = file_q[faddr_q];
               OFS_WDOG:
               begin
                  prdata_d[7:0] = watchdog_counter_q;
                  prdata_d[WD_PRESC_LSB +: 8] = presc_q;
               end
               default: prdata_d = WORD_ZERO;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= WORD_ZERO;
      end
      else
      begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // ****************************************
   // Core: software writes, then instruction execution
   // ****************************************
   always_comb
   begin
      state_d = state_q;
      instr_d = instr_q;
      acc_d = acc_q;
      carry_d = carry_q;
      dcarry_d = dcarry_q;
      zero_d = zero_q;
      timeout_flag_n_d = timeout_flag_n_q;
      powerdown_flag_n_d = powerdown_flag_n_q;
      pc_d = pc_q;
      sp_d = sp_q;
      stack_d = stack_q;
      faddr_d = faddr_q;
      file_d = file_q;
      watchdog_counter_d = watchdog_counter_q;
      presc_d = presc_q;

      // The watchdog here is clocked from the core oscillator, so it stands still in sleep.
      if (state_q != ST_SLEEPING)
      begin
         presc_d = presc_q + 8'h01;
         if (presc_q == PRESC_LAST)
         begin
            watchdog_counter_d = watchdog_counter_q + 8'h01;
         end
      end

      if (wr_fire && is_mapped(paddr))
      begin
         unique case (paddr)
            OFS_INSTR:
            begin
               // An instruction is only taken when the core is idle; otherwise it is dropped.
               if (state_q == ST_IDLE)
               begin
                  instr_d = pwdata[INSTR_W-1:0];
                  state_d = ST_EXEC;
               end
            end
            OFS_ACC: acc_d = pwdata[7:0];
            OFS_STATUS:
            begin
               carry_d = pwdata[ST_C];
               dcarry_d = pwdata[ST_DIGIT];
               zero_d = pwdata[ST_Z];
            end
            OFS_PC: pc_d = pwdata[PC_W-1:0];
            OFS_STACK:
            begin
               stack_d[sp_q] = pwdata[PC_W-1:0];
               sp_d = sp_q + 3'h1;
            end
            OFS_FADDR: faddr_d = pwdata[FADDR_W-1:0];
            OFS_FDATA: file_d[faddr_q] = pwdata[7:0];
            OFS_WAKE:
            begin
               state_d = (state_q == ST_SLEEPING && pwdata[WAKE_BIT]) ? ST_IDLE : state_q;
            end
            // The watchdog word is read-only; a write to it lands here and must not stall it.
            default: state_d = state_q;
         endcase
      end

      unique case (state_q)
         // Idle and sleep only leave on a bus write, which the decode above handles.
         ST_IDLE, ST_SLEEPING: state_d = state_d;
         ST_EXEC:
         begin
            state_d = ST_IDLE;
            pc_d = pc_q + 13'h0001;
            unique case (op)
               OP_SLEEP:
               begin
                  watchdog_counter_d = WDOG_CLEAR;
                  presc_d = PRESC_CLEAR;
                  powerdown_flag_n_d = 1'b0;
                  timeout_flag_n_d = 1'b1;
                  state_d = ST_SLEEPING;
               end
               OP_RETURN:
               begin
                  // Flags are left untouched here on purpose.
                  sp_d = sp_q - 3'h1;
                  pc_d = stack_q[sp_d];
                  state_d = ST_FLUSH;
               end
               OP_SUBL:
               begin
                  acc_d = alu_res;
                  carry_d = alu_c;
                  dcarry_d = alu_dc;
                  zero_d = alu_z;
               end
               OP_RRC:
               begin
                  carry_d = alu_c;
                  if (dest_file)
                  begin
                     file_d[op_faddr] = alu_res;
                  end
                  else
                  begin
                     acc_d = alu_res;
                  end
               end
               OP_SUBF:
               begin
                  carry_d = alu_c;
                  dcarry_d = alu_dc;
                  zero_d = alu_z;
                  if (dest_file)
                  begin
                     file_d[op_faddr] = alu_res;
                  end
                  else
                  begin
                     acc_d = alu_res;
                  end
               end
               default: state_d = ST_IDLE;
            endcase
         end
         ST_FLUSH: state_d = ST_IDLE;
      endcase

      osc_run_d = (state_d != ST_SLEEPING);
      sleeping_d = (state_d == ST_SLEEPING);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         instr_q <= INSTR_RESET;
         acc_q <= BYTE_ZERO;
         carry_q <= 1'b0;
         dcarry_q <= 1'b0;
         zero_q <= 1'b0;
         timeout_flag_n_q <= 1'b1;
         powerdown_flag_n_q <= 1'b1;
         pc_q <= PC_RESET;
         sp_q <= SP_RESET;
         stack_q <= '{default: PC_RESET};
         faddr_q <= '0;
         file_q <= '{default: BYTE_ZERO};
         watchdog_counter_q <= WDOG_CLEAR;
         presc_q <= PRESC_CLEAR;
         osc_run_q <= 1'b1;
         sleeping_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         instr_q <= instr_d;
         acc_q <= acc_d;
         carry_q <= carry_d;
         dcarry_q <= dcarry_d;
         zero_q <= zero_d;
         timeout_flag_n_q <= timeout_flag_n_d;
         powerdown_flag_n_q <= powerdown_flag_n_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         stack_q <= stack_d;
         faddr_q <= faddr_d;
         file_q <= file_d;
         watchdog_counter_q <= watchdog_counter_d;
         presc_q <= presc_d;
         osc_run_q <= osc_run_d;
         sleeping_q <= sleeping_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign osc_run = osc_run_q;
   assign sleeping = sleeping_q;

endmodule : srsre_top

// ==== tb/srsre_asserts.sv ====
// Port-level checker for the instruction execution block.
// Assumes the one-wait-state APB answer and the sleep and wake paths of srsre_top.
`timescale 1ns/1ps
module srsre_asserts
   import srsre_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_run,
   input wire logic sleeping
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   logic mapped;
   logic wr_done;
   logic sleep_go;
   logic wake_go;
   assign mapped = (paddr <= OFS_WAKE) && (paddr[1:0] == 2'h0);
   assign wr_done = psel && penable && pready && pwrite;
   assign sleep_go = wr_done && (paddr == OFS_INSTR) && (pwdata[OP_MSB:OP_LSB] == OP_SLEEP);
   assign wake_go = wr_done && (paddr == OFS_WAKE) && pwdata[WAKE_BIT];

   sequence s_access_start;
      psel && penable && !pready;
   endsequence
   sequence s_enter_sleep;
      sleep_go && !sleeping ##2 sleeping && !osc_run;
   endsequence
   sequence s_leave_sleep;
      sleeping && wake_go ##1 !sleeping && osc_run;
   endsequence

   a_ready_one_wait: assert property (s_access_start |=> pready)
      else $error("ready did not follow the access phase");
   a_ready_one_pulse: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("error flag does not match the address map");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == WORD_ZERO)
      else $error("refused read returned data");
   a_sleep_entry: assert property (sleep_go && !sleeping |-> s_enter_sleep)
      else $error("power-down did not stop the oscillator");
   a_sleep_holds: assert property (sleeping && !wake_go |=> sleeping)
      else $error("sleep left without a wake request");
   a_wake_exit: assert property (sleeping && wake_go |-> s_leave_sleep)
      else $error("wake request did not restart the oscillator");
   a_osc_halted: assert property (osc_run != sleeping)
      else $error("oscillator state disagrees with sleep state");
   a_sleep_cause: assert property ($rose(sleeping) |-> $past(sleep_go, 2))
      else $error("sleep entered without a power-down instruction");
endmodule : srsre_asserts

bind srsre_top srsre_asserts srsre_asserts_i (.clk(clk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .osc_run(osc_run), .sleeping(sleeping));

// ==== tb/sleep_return_sub_rotate_exec_tb.sv ====
// Self-checking bench for the instruction execution block.
// Assumes srsre_top with its APB register map; the bench is the only APB master.
`timescale 1ns/1ps
module sleep_return_sub_rotate_exec_tb
   import srsre_pkg::*;
;
   logic clk, srst, psel, penable, pwrite, pready, pslverr, osc_run, sleeping, err, c;
   logic [7:0] paddr, k, w, f, r;
   logic [31:0] pwdata, prdata, rdat;
   logic [6:0] a;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] kt [5] = '{8'h05, 8'h02, 8'h01, 8'h10, 8'hff};
   logic [7:0] wt [5] = '{8'h03, 8'h02, 8'h02, 8'h01, 8'h00};

   srsre_top srsre_top_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_run(osc_run), .sleeping(sleeping));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // Bus tasks and comparison
   // ****************************************
   task final_report;
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   // An idle cycle follows each transfer so that no signal is assigned twice in one step.
   task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int n;
      logic late;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      late = (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (late)
      begin
         $display("unexpected at %0t: no ready", $time);
         fail_count++;
         final_report();
      end
   endtask : apb

   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask : wr

   task rd(input logic [7:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, WORD_ZERO);
      chk(rdat, exp);
   endtask : rd

   // Returns {zero, digit carry, carry} of x - y, carry high when no borrow.
   function logic [2:0] subfl(input logic [7:0] x, input logic [7:0] y);
      logic [7:0] t;
      t = x - y;
      return {t == 8'h00, x[3:0] >= y[3:0], x >= y};
   endfunction : subfl

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(OFS_STATUS, 32'h18);
      rd(OFS_ACC, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rdat, 32'h0);
      wr(8'h24, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         k = kt[i];
         w = wt[i];
         wr(OFS_ACC, {24'h0, w});
         wr(OFS_INSTR, {21'h0, OP_SUBL, k});
         rd(OFS_ACC, {24'h0, k - w});
         rd(OFS_STATUS, {27'h3, subfl(k, w)});
      end
      rd(OFS_PC, 32'h5);
      for (int d = 0; d < 2; d++)
      begin
         f = 8'h20 + 8'(d);
         w = 8'h21;
         a = d[0] ? 7'h7f : 7'h00;
         wr(OFS_FADDR, {25'h0, a});
         wr(OFS_FDATA, {24'h0, f});
         wr(OFS_ACC, {24'h0, w});
         wr(OFS_INSTR, {21'h0, OP_SUBF, d[0], a});
         rd(OFS_ACC, {24'h0, d[0] ? w : f - w});
         rd(OFS_FDATA, {24'h0, d[0] ? f - w : f});
         rd(OFS_STATUS, {27'h3, subfl(f, w)});
      end
      for (int i = 0; i < 4; i++)
      begin
         c = i[0];
         f = i[1] ? 8'h81 : 8'h4a;
         r = {c, f[7:1]};
         wr(OFS_FADDR, 32'h33);
         wr(OFS_FDATA, {24'h0, f});
         wr(OFS_ACC, 32'h5a);
         wr(OFS_STATUS, {29'h0, 2'b11, c});
         wr(OFS_INSTR, {21'h0, OP_RRC, i[1], 7'h33});
         rd(OFS_ACC, {24'h0, i[1] ? 8'h5a : r});
         rd(OFS_FDATA, {24'h0, i[1] ? r : f});
         rd(OFS_STATUS, {27'h3, 2'b11, f[0]});
      end
      wr(OFS_STATUS, 32'h5);
      wr(OFS_STACK, 32'h0abc);
      wr(OFS_STACK, 32'h1fff);
      rd(OFS_STACK, 32'h2);
      wr(OFS_INSTR, {21'h0, OP_RETURN, 8'h00});
      rd(OFS_PC, 32'h1fff);
      rd(OFS_STACK, 32'h1);
      rd(OFS_STATUS, 32'h1d);
      wr(OFS_INSTR, {21'h0, OP_RETURN, 8'h00});
      rd(OFS_PC, 32'h0abc);
      apb(1'b0, OFS_WDOG, 32'h0);
      chk({31'h0, rdat != 32'h0}, 32'h1);
      wr(OFS_INSTR, {21'h0, OP_SLEEP, 8'h00});
      rd(OFS_WDOG, 32'h0);
      rd(OFS_STATUS, 32'h35);
      chk({30'h0, osc_run, sleeping}, 32'h1);
      wr(OFS_ACC, 32'h07);
      wr(OFS_INSTR, {21'h0, OP_SUBL, 8'h09});
      rd(OFS_ACC, 32'h07);
      rd(OFS_WDOG, 32'h0);
      wr(OFS_WAKE, 32'h1);
      rd(OFS_STATUS, 32'h15);
      chk({30'h0, osc_run, sleeping}, 32'h2);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(OFS_STATUS, 32'h18);
      rd(OFS_PC, 32'h0);
      final_report();
   end
endmodule : sleep_return_sub_rotate_exec_tb
